// file: design/osc_config_fuse_decoder.sv
// Oscillator configuration fuse decoder with AHB-Lite register access
// Overview of operation
// RQ1 - Switch/monitor field: 1x both off, 01 switching only, 00 both on.
// RQ2 - Two-bit group: 11 primary, 10 low-power RC, 01 fast RC, 00 crystal.
// RQ3 - Unimplemented bits of the configuration word read as zero.
// RQ4 - Two-bit layout: mode bits 3-0, group bits 9-8, switch bits 15-14.
// RQ5 - Primary external clock and external RC modes, with PLL 4x/8x/16x.
// RQ6 - Mid, low and high crystal modes, mid crystal with PLL options.
// RQ7 - Fast RC through PLL: 0001 4x, 1010 8x, 0011 16x, pin free.
// RQ8 - Erased word gives external clock, PLL 16x, output pin as I/O.
// RQ9 - Output pin function follows mode field; input pin never I/O.
// RQ10 - Three-bit group: 111 PLL, 011 external, 010, 001, 000 internal/secondary.
// RQ11 - Three-bit layout uses a 5-bit mode field for PLL and external choice.
// RQ12 - PLL group: external clock and fast RC codes at 4x, 8x, 16x.
// RQ13 - PLL group: mid crystal, high band two and three at 4x, 8x, 16x.
// RQ14 - External group codes decoded without the PLL.
// RQ15 - Three-bit layout: group at bits 10-8, mode at bits 4-0.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "osc_fuse_map.svh"
module osc_config_fuse_decoder (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [23:0]         fuse_word,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic                     clk_switch_en,
  output logic                     fail_safe_mon_en,
  output osc_fuse_pkg::src_t       reset_source,
  output osc_fuse_pkg::kind_t      primary_kind,
  output osc_fuse_pkg::pll_t       pll_mult,
  output osc_fuse_pkg::pin_t       osc_output_pin_fn,
  output logic                     osc_input_pin_io,
  output logic                     config_valid
);

  logic [23:0]              fuse_ff;
  logic                     layout_three_ff;
  logic                     reload_ff;
  osc_fuse_pkg::cap_state_t cap_state_ff;
  osc_fuse_pkg::cap_state_t nxt_cap_state;
  logic                     wr_pend_ff;
  logic [11:0]              wr_addr_ff;
  logic                     rd_pend_ff;

  osc_fuse_pkg::src_t       src2;
  osc_fuse_pkg::kind_t      kind2;
  osc_fuse_pkg::pll_t       pll2;
  osc_fuse_pkg::pin_t       pin2;
  osc_fuse_pkg::src_t       src3;
  osc_fuse_pkg::kind_t      kind3;
  osc_fuse_pkg::pll_t       pll3;
  osc_fuse_pkg::pin_t       pin3;

  logic                     addr_phase;
  logic [1:0]               swmon;
  logic [31:0]              status_word;
  logic [31:0]              rd_word;

  // Switch/monitor field, same in both layouts
  function automatic logic [1:0] swmon_decode(input logic [1:0] field);
    logic [1:0] en;
    en = 2'h0;
    case (field)
      2'h0:    en = 2'h3;  // [RQ1]
      2'h1:    en = 2'h1;  // [RQ1]
      default: en = 2'h0;  // [RQ1]
    endcase
    return en;
  endfunction : swmon_decode

  // Register map decode, used by both read and write paths
  function automatic logic [1:0] reg_index(input logic [11:0] a);
    return a[3:2];
  endfunction : reg_index

  fuse_decode_two_bit u_two (
    .por_source_group    (fuse_ff[`GRP2_HI:`GRP2_LO]),   // [RQ4]
    .primary_mode_select (fuse_ff[`PRIM4_HI:`PRIM4_LO]), // [RQ4]
    .src                 (src2),
    .kind                (kind2),
    .pll                 (pll2),
    .pin                 (pin2)
  );

  fuse_decode_three_bit u_three (
    .por_source_group    (fuse_ff[`GRP3_HI:`GRP3_LO]),   // [RQ15]
    .primary_mode_select (fuse_ff[`PRIM5_HI:`PRIM5_LO]), // [RQ15] [RQ11]
    .src                 (src3),
    .kind                (kind3),
    .pll                 (pll3),
    .pin                 (pin3)
  );

  assign swmon      = swmon_decode(fuse_ff[`SWMON_HI:`SWMON_LO]);
  assign addr_phase = hsel & hready & htrans[1];

  // Fuse word is read once after reset, and again on a reload request
  always_comb
  begin
    nxt_cap_state = cap_state_ff;
    case (cap_state_ff)
      osc_fuse_pkg::st_capture: nxt_cap_state = osc_fuse_pkg::st_run;
      osc_fuse_pkg::st_run:
      begin
        if (reload_ff)
        begin
          nxt_cap_state = osc_fuse_pkg::st_capture;
        end
      end
      default: nxt_cap_state = osc_fuse_pkg::st_capture;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_state_ff <= osc_fuse_pkg::st_capture;
    end
    else
    begin
      cap_state_ff <= nxt_cap_state;
    end
  end

  // Erased value until the first capture, so outputs start in the default mode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fuse_ff <= `FUSE_ERASED;  // [RQ8]
    end
    else if (cap_state_ff == osc_fuse_pkg::st_capture)
    begin
      fuse_ff <= fuse_word;
    end
  end

  // Bus address phase capture; zero wait states
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_ff <= addr_phase & hwrite;
      rd_pend_ff <= addr_phase & ~hwrite;
      wr_addr_ff <= haddr[11:0];
    end
  end

  // Control register; reload is a self-clearing pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      layout_three_ff <= 1'b0;
      reload_ff       <= 1'b0;
    end
    else
    begin
      reload_ff <= 1'b0;
      if (wr_pend_ff && wr_addr_ff[11:4] == 8'h00 &&
          reg_index(wr_addr_ff) == reg_index(`OFS_CTRL))
      begin
        layout_three_ff <= hwdata[`CTRL_LAYOUT_BIT];
        reload_ff       <= hwdata[`CTRL_RELOAD_BIT];
      end
    end
  end

  assign status_word = {15'h0000, config_valid, 2'h0, fail_safe_mon_en, clk_switch_en,
                        osc_output_pin_fn, pll_mult, 1'b0, primary_kind, reset_source};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (haddr[11:4] == 8'h00)
    begin
      case (reg_index(haddr[11:0]))
        reg_index(`OFS_CTRL):       rd_word = {31'h0000_0000, layout_three_ff};
        // Unimplemented bits are masked off [RQ3]
        reg_index(`OFS_FUSE_TWO):   rd_word = {8'h00, fuse_ff & `MASK_TWO_BIT};
        reg_index(`OFS_FUSE_THREE): rd_word = {8'h00, fuse_ff & `MASK_THREE_BIT};
        reg_index(`OFS_STATUS):     rd_word = status_word;
        default:                    rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered in the address phase, shown in the data phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addr_phase && !hwrite)
    begin
      hrdata <= rd_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Decoded outputs, registered from the captured word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_switch_en     <= 1'b0;
      fail_safe_mon_en  <= 1'b0;
      reset_source      <= osc_fuse_pkg::src_primary;
      primary_kind      <= osc_fuse_pkg::kind_ext_clock_in;
      pll_mult          <= osc_fuse_pkg::pll_x16;
      osc_output_pin_fn <= osc_fuse_pkg::pin_io;
      config_valid      <= 1'b0;
    end
    else
    begin
      clk_switch_en    <= swmon[0];  // [RQ1]
      fail_safe_mon_en <= swmon[1];  // [RQ1]
      config_valid     <= (cap_state_ff == osc_fuse_pkg::st_run);
      if (layout_three_ff)
      begin
        reset_source      <= src3;  // [RQ10]
        primary_kind      <= kind3;
        pll_mult          <= pll3;
        osc_output_pin_fn <= pin3;  // [RQ9]
      end
      else
      begin
        reset_source      <= src2;  // [RQ2]
        primary_kind      <= kind2;
        pll_mult          <= pll2;
        osc_output_pin_fn <= pin2;  // [RQ9]
      end
    end
  end

  // Input oscillator pin never released as I/O
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_input_pin_io <= 1'b0;
    end
    else
    begin
      osc_input_pin_io <= 1'b0;  // [RQ9]
    end
  end

endmodule : osc_config_fuse_decoder

// file: design/osc_fuse_map.svh
// Offsets, field positions, reset values and timing counts of the fuse decoder
`ifndef OSC_FUSE_MAP_SVH
`define OSC_FUSE_MAP_SVH

`define OFS_CTRL        12'h000
`define OFS_FUSE_TWO    12'h004
`define OFS_FUSE_THREE  12'h008
`define OFS_STATUS      12'h00C

`define CTRL_LAYOUT_BIT 0
`define CTRL_RELOAD_BIT 1

`define SWMON_HI        15
`define SWMON_LO        14
`define GRP2_HI         9
`define GRP2_LO         8
`define PRIM4_HI        3
`define PRIM4_LO        0
`define GRP3_HI         10
`define GRP3_LO         8
`define PRIM5_HI        4
`define PRIM5_LO        0

`define MASK_TWO_BIT    24'h00_C30F
`define MASK_THREE_BIT  24'h00_C71F
`define FUSE_ERASED     24'hFF_FFFF

`define CAPTURE_CYCLES  2'h1

`endif

// file: design/osc_fuse_pkg.sv
// Types shared by the fuse decoder modules
package osc_fuse_pkg;

  typedef enum logic [2:0] {
    src_secondary_low_power_crystal = 3'h0,
    src_internal_fast_rc            = 3'h1,
    src_internal_low_power_rc       = 3'h2,
    src_primary                     = 3'h3,
    src_reserved                    = 3'h4,
    src_pll_group                   = 3'h7
  } src_t;

  typedef enum logic [3:0] {
    kind_none                 = 4'h0,
    kind_ext_clock_in         = 4'h1,
    kind_ext_rc               = 4'h2,
    kind_crystal_low          = 4'h3,
    kind_crystal_mid          = 4'h4,
    kind_crystal_high         = 4'h5,
    kind_crystal_high_band_two   = 4'h6,
    kind_crystal_high_band_three = 4'h7,
    kind_internal_fast_rc     = 4'h8,
    kind_reserved             = 4'hF
  } kind_t;

  typedef enum logic [1:0] {
    pll_off = 2'h0,
    pll_x4  = 2'h1,
    pll_x8  = 2'h2,
    pll_x16 = 2'h3
  } pll_t;

  typedef enum logic [1:0] {
    pin_io              = 2'h0,
    pin_cycle_clock_out = 2'h1,
    pin_crystal         = 2'h2,
    pin_unknown         = 2'h3
  } pin_t;

  typedef enum logic [1:0] {
    st_capture = 2'b01,
    st_run     = 2'b10
  } cap_state_t;

endpackage : osc_fuse_pkg

// file: design/fuse_decode_two_bit.sv
// Combinational decode of the 2-bit source group layout
`timescale 1ns/1ps
module fuse_decode_two_bit (
  input  wire logic [1:0]          por_source_group,
  input  wire logic [3:0]          primary_mode_select,
  output osc_fuse_pkg::src_t       src,
  output osc_fuse_pkg::kind_t      kind,
  output osc_fuse_pkg::pll_t       pll,
  output osc_fuse_pkg::pin_t       pin
);

  osc_fuse_pkg::kind_t prim_kind;
  osc_fuse_pkg::pll_t  prim_pll;
  osc_fuse_pkg::pin_t  prim_pin;

  always_comb
  begin
    prim_kind = osc_fuse_pkg::kind_reserved;
    prim_pll  = osc_fuse_pkg::pll_off;
    prim_pin  = osc_fuse_pkg::pin_unknown;
    case (primary_mode_select)
      4'hB:
      begin
        prim_kind = osc_fuse_pkg::kind_ext_clock_in;
        prim_pin  = osc_fuse_pkg::pin_cycle_clock_out;  // [RQ5]
      end
      4'hC, 4'hD, 4'hE, 4'hF:
      begin
        prim_kind = osc_fuse_pkg::kind_ext_clock_in;
        prim_pin  = osc_fuse_pkg::pin_io;  // [RQ5] [RQ8]
        prim_pll  = osc_fuse_pkg::pll_t'(primary_mode_select[1:0]);
      end
      4'h9:
      begin
        prim_kind = osc_fuse_pkg::kind_ext_rc;
        prim_pin  = osc_fuse_pkg::pin_cycle_clock_out;  // [RQ5]
      end
      4'h8:
      begin
        prim_kind = osc_fuse_pkg::kind_ext_rc;
        prim_pin  = osc_fuse_pkg::pin_io;  // [RQ5]
      end
      4'h4, 4'h5, 4'h6, 4'h7:
      begin
        prim_kind = osc_fuse_pkg::kind_crystal_mid;
        prim_pin  = osc_fuse_pkg::pin_crystal;  // [RQ6]
        prim_pll  = osc_fuse_pkg::pll_t'(primary_mode_select[1:0]);
      end
      4'h0:
      begin
        prim_kind = osc_fuse_pkg::kind_crystal_low;
        prim_pin  = osc_fuse_pkg::pin_crystal;  // [RQ6]
      end
      4'h2:
      begin
        prim_kind = osc_fuse_pkg::kind_crystal_high;
        prim_pin  = osc_fuse_pkg::pin_crystal;  // [RQ6]
      end
      4'h1, 4'h3:
      begin
        prim_kind = osc_fuse_pkg::kind_internal_fast_rc;
        prim_pin  = osc_fuse_pkg::pin_io;  // [RQ7]
        prim_pll  = primary_mode_select[1] ? osc_fuse_pkg::pll_x16 : osc_fuse_pkg::pll_x4;
      end
      4'hA:
      begin
        // Odd code for the 8x fast RC; kept as printed
        prim_kind = osc_fuse_pkg::kind_internal_fast_rc;
        prim_pin  = osc_fuse_pkg::pin_io;  // [RQ7]
        prim_pll  = osc_fuse_pkg::pll_x8;
      end
      default:
      begin
        prim_kind = osc_fuse_pkg::kind_reserved;
      end
    endcase
  end

  always_comb
  begin
    src  = osc_fuse_pkg::src_t'({1'b0, por_source_group});  // [RQ2]
    kind = osc_fuse_pkg::kind_none;
    pll  = osc_fuse_pkg::pll_off;
    // Output pin follows the mode field whatever the source
    pin  = prim_pin;  // [RQ9]
    if (por_source_group == 2'h3)
    begin
      kind = prim_kind;
      pll  = prim_pll;
    end
  end

endmodule : fuse_decode_two_bit

// file: design/fuse_decode_three_bit.sv
// Combinational decode of the 3-bit source group layout
`timescale 1ns/1ps
module fuse_decode_three_bit (
  input  wire logic [2:0]          por_source_group,
  input  wire logic [4:0]          primary_mode_select,
  output osc_fuse_pkg::src_t       src,
  output osc_fuse_pkg::kind_t      kind,
  output osc_fuse_pkg::pll_t       pll,
  output osc_fuse_pkg::pin_t       pin
);

  osc_fuse_pkg::kind_t pk;
  osc_fuse_pkg::pin_t  pp;
  osc_fuse_pkg::pll_t  pm;
  osc_fuse_pkg::kind_t ek;
  osc_fuse_pkg::pin_t  ep;

  // PLL group table [RQ11]
  always_comb
  begin
    pk = osc_fuse_pkg::kind_reserved;
    pp = osc_fuse_pkg::pin_unknown;
    pm = osc_fuse_pkg::pll_off;
    if (primary_mode_select[1:0] != 2'h0)
    begin
      pm = osc_fuse_pkg::pll_t'(primary_mode_select[1:0]);
      case (primary_mode_select[4:2])
        3'h3:
        begin
          pk = osc_fuse_pkg::kind_ext_clock_in;
          pp = osc_fuse_pkg::pin_io;  // [RQ12]
        end
        3'h1:
        begin
          pk = osc_fuse_pkg::kind_crystal_mid;
          pp = osc_fuse_pkg::pin_crystal;  // [RQ13]
        end
        3'h4:
        begin
          pk = osc_fuse_pkg::kind_crystal_high_band_two;
          pp = osc_fuse_pkg::pin_crystal;  // [RQ13]
        end
        3'h5:
        begin
          pk = osc_fuse_pkg::kind_crystal_high_band_three;
          pp = osc_fuse_pkg::pin_crystal;  // [RQ13]
        end
        default:
        begin
          pm = osc_fuse_pkg::pll_off;
        end
      endcase
    end
    case (primary_mode_select)
      5'h01, 5'h0A, 5'h03:
      begin
        pk = osc_fuse_pkg::kind_internal_fast_rc;
        pp = osc_fuse_pkg::pin_io;  // [RQ12]
        pm = (primary_mode_select == 5'h0A) ? osc_fuse_pkg::pll_x8
           : osc_fuse_pkg::pll_t'(primary_mode_select[1:0]);
      end
      default:
      begin
      end
    endcase
  end

  // External group table, no PLL [RQ14]
  always_comb
  begin
    ek = osc_fuse_pkg::kind_reserved;
    ep = osc_fuse_pkg::pin_unknown;
    case (primary_mode_select)
      5'h0C:
      begin
        ek = osc_fuse_pkg::kind_ext_clock_in;
        ep = osc_fuse_pkg::pin_io;
      end
      5'h0B:
      begin
        ek = osc_fuse_pkg::kind_ext_clock_in;
        ep = osc_fuse_pkg::pin_cycle_clock_out;
      end
      5'h09:
      begin
        ek = osc_fuse_pkg::kind_ext_rc;
        ep = osc_fuse_pkg::pin_cycle_clock_out;
      end
      5'h08:
      begin
        ek = osc_fuse_pkg::kind_ext_rc;
        ep = osc_fuse_pkg::pin_io;
      end
      5'h04:
      begin
        ek = osc_fuse_pkg::kind_crystal_mid;
        ep = osc_fuse_pkg::pin_crystal;
      end
      5'h02:
      begin
        ek = osc_fuse_pkg::kind_crystal_high;
        ep = osc_fuse_pkg::pin_crystal;
      end
      5'h00:
      begin
        ek = osc_fuse_pkg::kind_crystal_low;
        ep = osc_fuse_pkg::pin_crystal;
      end
      default:
      begin
      end
    endcase
  end

  always_comb
  begin
    kind = osc_fuse_pkg::kind_none;
    pll  = osc_fuse_pkg::pll_off;
    pin  = (ep != osc_fuse_pkg::pin_unknown) ? ep : pp;  // [RQ9]
    case (por_source_group)
      3'h7:
      begin
        src  = osc_fuse_pkg::src_pll_group;  // [RQ10]
        kind = pk;
        pll  = pm;
        pin  = pp;
      end
      3'h3:
      begin
        src  = osc_fuse_pkg::src_primary;  // [RQ10]
        kind = ek;
        pin  = ep;
      end
      3'h2:    src = osc_fuse_pkg::src_internal_low_power_rc;  // [RQ10]
      3'h1:    src = osc_fuse_pkg::src_internal_fast_rc;  // [RQ10]
      3'h0:    src = osc_fuse_pkg::src_secondary_low_power_crystal;  // [RQ10]
      default: src = osc_fuse_pkg::src_reserved;
    endcase
  end

endmodule : fuse_decode_three_bit

// file: test/fuse_store_model.sv
// Behavioural model of the nonvolatile configuration storage
`timescale 1ns/1ps
module fuse_store_model (
  input  wire logic        clock,
  input  wire logic        prog_en,
  input  wire logic [23:0] prog_word,
  output logic      [23:0] fuse_word
);
  // Unprogrammed cells read as ones until the bench programs a word
  initial fuse_word = 24'hFF_FFFF;
  // Plain always so the power-up value and programming share one variable
  always @(posedge clock)
    if (prog_en)
      fuse_word <= prog_word;
endmodule : fuse_store_model

// file: test/osc_fuse_checker.sv
// Concurrent checks on the fuse decoder ports
`timescale 1ns/1ps
module osc_fuse_checker (
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic [23:0]     fuse_word,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic            clk_switch_en,
  input wire logic            fail_safe_mon_en,
  input osc_fuse_pkg::src_t   reset_source,
  input osc_fuse_pkg::kind_t  primary_kind,
  input osc_fuse_pkg::pll_t   pll_mult,
  input osc_fuse_pkg::pin_t   osc_output_pin_fn,
  input wire logic            osc_input_pin_io,
  input wire logic            config_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_mon_needs_switch: assert property (fail_safe_mon_en |-> clk_switch_en)
    else $error("monitor enabled without switching");
  a_swmon_capture: assert property ($rose(config_valid) |->
    clk_switch_en == !$past(fuse_word[15]) && fail_safe_mon_en == ($past(fuse_word[15:14]) == 2'b00))
    else $error("switch monitor decode wrong after capture");
  a_input_pin_never_io: assert property (osc_input_pin_io == 1'b0)
    else $error("input oscillator pin released as io");
  a_reset_erased: assert property ($rose(rst_n) |->
    reset_source == osc_fuse_pkg::src_primary && primary_kind == osc_fuse_pkg::kind_ext_clock_in
    && pll_mult == osc_fuse_pkg::pll_x16 && osc_output_pin_fn == osc_fuse_pkg::pin_io && !config_valid)
    else $error("reset decode is not the erased default");
  a_fast_rc_pll: assert property (primary_kind == osc_fuse_pkg::kind_internal_fast_rc |->
    pll_mult != osc_fuse_pkg::pll_off && osc_output_pin_fn == osc_fuse_pkg::pin_io)
    else $error("fast rc mode without pll or pin free");
  a_crystal_pin: assert property (primary_kind inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7} |->
    osc_output_pin_fn == osc_fuse_pkg::pin_crystal)
    else $error("crystal mode not using both pins");
  a_pll_kinds: assert property (pll_mult != osc_fuse_pkg::pll_off |->
    primary_kind inside {4'h1, 4'h4, 4'h6, 4'h7, 4'h8})
    else $error("pll on for a mode without pll");
  a_reserved_code: assert property (primary_kind == osc_fuse_pkg::kind_reserved |->
    pll_mult == osc_fuse_pkg::pll_off && osc_output_pin_fn == osc_fuse_pkg::pin_unknown)
    else $error("reserved code decoded as a mode");
  a_non_primary_none: assert property (config_valid && reset_source inside {3'h0, 3'h1, 3'h2} |->
    primary_kind == osc_fuse_pkg::kind_none && pll_mult == osc_fuse_pkg::pll_off)
    else $error("mode field used for a non primary source");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite && haddr[11:4] != 8'h00
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  c_capture: cover property ($rose(config_valid));
  c_reserved: cover property (primary_kind == osc_fuse_pkg::kind_reserved);
  c_monitor: cover property (fail_safe_mon_en);
  c_pll_x8: cover property (pll_mult == osc_fuse_pkg::pll_x8);
endmodule : osc_fuse_checker

bind osc_config_fuse_decoder osc_fuse_checker u_chk (
  .clock, .rst_n, .fuse_word, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .clk_switch_en, .fail_safe_mon_en, .reset_source,
  .primary_kind, .pll_mult, .osc_output_pin_fn, .osc_input_pin_io, .config_valid
);

// file: test/osc_config_fuse_decoder_tb.sv
// Self-checking bench for the oscillator fuse decoder
`timescale 1ns/1ps
`include "osc_fuse_map.svh"
module osc_config_fuse_decoder_tb;
  logic                 clock, rst_n, hsel, hwrite, hready, prog_en;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [31:0]          haddr, hwdata, hrdata, rs;
  logic [23:0]          prog_word, fuse_word, w;
  logic                 hreadyout, hresp, clk_switch_en, fail_safe_mon_en;
  logic                 osc_input_pin_io, config_valid;
  osc_fuse_pkg::src_t   reset_source;
  osc_fuse_pkg::kind_t  primary_kind;
  osc_fuse_pkg::pll_t   pll_mult;
  osc_fuse_pkg::pin_t   osc_output_pin_fn;
  int                   err_count, checked;

  assign hready = hreadyout;

  fuse_store_model u_fuse (.clock(clock), .prog_en(prog_en), .prog_word(prog_word),
    .fuse_word(fuse_word));
  osc_config_fuse_decoder dut (.clock, .rst_n, .fuse_word, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .clk_switch_en, .fail_safe_mon_en,
    .reset_source, .primary_kind, .pll_mult, .osc_output_pin_fn, .osc_input_pin_io,
    .config_valid);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Entries are {kind, pll, pin} in the package encodings
  function automatic logic [7:0] two_tab(input logic [3:0] m);
    case (m)
      4'hF: return 8'h1C; 4'hE: return 8'h18; 4'hD: return 8'h14; 4'hC: return 8'h10;
      4'hB: return 8'h11; 4'h9: return 8'h21; 4'h8: return 8'h20; 4'h7: return 8'h4E;
      4'h6: return 8'h4A; 4'h5: return 8'h46; 4'h4: return 8'h42; 4'h0: return 8'h32;
      4'h2: return 8'h52; 4'h1: return 8'h84; 4'hA: return 8'h88; default: return 8'h8C;
    endcase
  endfunction : two_tab

  function automatic logic [7:0] pll_tab(input logic [4:0] m);
    case (m)
      5'h0D: return 8'h14; 5'h0E: return 8'h18; 5'h0F: return 8'h1C; 5'h01: return 8'h84;
      5'h0A: return 8'h88; 5'h03: return 8'h8C; 5'h05: return 8'h46; 5'h06: return 8'h4A;
      5'h07: return 8'h4E; 5'h11: return 8'h66; 5'h12: return 8'h6A; 5'h13: return 8'h6E;
      5'h15: return 8'h76; 5'h16: return 8'h7A; 5'h17: return 8'h7E; default: return 8'hF3;
    endcase
  endfunction : pll_tab

  function automatic logic [7:0] ext_tab(input logic [4:0] m);
    case (m)
      5'h0C: return 8'h10; 5'h04: return 8'h42; 5'h02: return 8'h52; 5'h0B: return 8'h11;
      5'h09: return 8'h21; 5'h08: return 8'h20; 5'h00: return 8'h32; default: return 8'hF3;
    endcase
  endfunction : ext_tab

  // Result is {source, kind, pll, pin}
  function automatic logic [10:0] expect_dec(input logic lay, input logic [23:0] x);
    logic [7:0] e;
    logic [2:0] g;
    g = lay ? x[10:8] : {1'b0, x[9:8]};
    if (!lay)
      e = two_tab(x[3:0]);
    else if (g == 3'h7)
      e = pll_tab(x[4:0]);
    else if (g == 3'h3)
      e = ext_tab(x[4:0]);
    else
      e = (ext_tab(x[4:0]) == 8'hF3) ? pll_tab(x[4:0]) : ext_tab(x[4:0]);
    // Secondary and internal sources still take the pin function from the mode field
    if (g != 3'h3 && g != 3'h7)
      e = {6'h00, e[1:0]};
    // Group codes 100 to 110 all report the one reserved source
    return {(g inside {3'h4, 3'h5, 3'h6}) ? 3'h4 : g, e};
  endfunction : expect_dec

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr; hsize <= 3'b010;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : bus

  task automatic check_ports(input logic lay, input logic [23:0] x);
    check("decode", {21'h0, reset_source, primary_kind, pll_mult, osc_output_pin_fn},
          {21'h0, expect_dec(lay, x)});
    check("swmon", {30'h0, clk_switch_en, fail_safe_mon_en},
          {30'h0, !x[15], x[15:14] == 2'b00});
    check("okay", {30'h0, hresp, osc_input_pin_io}, 32'h0);
  endtask : check_ports

  task automatic run_case(input logic lay, input logic [23:0] x);
    logic [31:0] rd;
    logic [10:0] e;
    e = expect_dec(lay, x);
    prog_word <= x;
    prog_en <= 1'b1;
    @(posedge clock);
    prog_en <= 1'b0;
    bus(1'b1, {20'h0, `OFS_CTRL}, {30'h0, 1'b1, lay}, rd);
    // Reload pulse, capture, then outputs: three edges after the write
    repeat (4) @(posedge clock);
    check_ports(lay, x);
    bus(1'b0, {20'h0, `OFS_STATUS}, 32'h0, rd);
    check("status", rd, {15'h0, 1'b1, 2'h0, x[15:14] == 2'b00, !x[15], e[1:0], e[3:2], 1'b0,
          e[7:4], e[10:8]});
    bus(1'b0, lay ? {20'h0, `OFS_FUSE_THREE} : {20'h0, `OFS_FUSE_TWO}, 32'h0, rd);
    check("view", rd, {8'h0, x & (lay ? `MASK_THREE_BIT : `MASK_TWO_BIT)});
    bus(1'b0, {20'h0, `OFS_CTRL}, 32'h0, rd);
    check("ctrl", rd, {31'h0, lay});
  endtask : run_case

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("MISMATCH watchdog expected done seen hang");
    summarize();
  end

  initial
  begin : main
    logic [31:0] rd;
    rst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; prog_en = 1'b0; prog_word = 24'h00_0000;
    rs = 32'h0000_0007; err_count = 0; checked = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_ports(1'b0, `FUSE_ERASED);
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_0010, 32'h0, rd);
    check("unmapped", rd, 32'h0000_0000);
    for (int i = 0; i < 64; i++)
    begin
      rs = xs(rs);
      w = rs[23:0];
      w[9:8] = i[5:4];
      w[3:0] = i[3:0];
      run_case(1'b0, w);
    end
    for (int i = 0; i < 256; i++)
    begin
      rs = xs(rs);
      w = rs[23:0];
      w[10:8] = i[7:5];
      w[4:0] = i[4:0];
      run_case(1'b1, w);
    end
    bus(1'b1, {20'h0, `OFS_CTRL}, 32'h0, rd);
    repeat (2) @(posedge clock);
    check_ports(1'b0, w);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_ports(1'b0, w);
    summarize();
  end
endmodule : osc_config_fuse_decoder_tb
